// File: core/led_pwm_cfg.svh
// register map, field positions, reset values and timing for the pwm block
`ifndef LED_PWM_CFG_SVH
`define LED_PWM_CFG_SVH
// register addresses
`define ADDR_INPUT_LEVELS 8'h00
`define ADDR_PHASE_ZERO 8'h01
`define ADDR_PORT_DIR 8'h03
`define ADDR_PHASE_ONE 8'h09
`define ADDR_MASTER 8'h0e
`define ADDR_CONFIG 8'h0f
`define ADDR_INDIV_BASE 8'h10
`define ADDR_INDIV_LAST 8'h13
// configuration bits
`define CFG_BLINK_EN 0
`define CFG_BLINK_FLIP 1
`define CFG_GLOBAL 2
`define CFG_INT_EN 3
`define CFG_NINTH_PH0 4
`define CFG_NINTH_PH1 5
`define CFG_WIDTH 6
// reset values
`define RST_PHASE 8'hff
`define RST_DIR 8'hff
`define RST_MASTER 8'h00
`define RST_CONFIG 6'h30
`define RST_INDIV 4'hf
// pwm step counts
`define SLOT_LAST 4'he
`define CYC_LAST 4'hf
`define INTENS_FULL 4'hf
// oscillator timing
`define CLOCK_HZ 250000000
`define OSC_HZ 32000
`endif

// File: core/led_pwm_pkg.sv
// shared types for the pwm output block
package led_pwm_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [3:0] nibble_t;
endpackage

// File: core/led_pwm_blink_output_control.sv
// pwm intensity and blink phase output logic with register port
`timescale 1ns/1ps
`include "led_pwm_cfg.svh"

module led_pwm_blink_output_control
#(
	parameter int OSC_DIV = `CLOCK_HZ / `OSC_HZ
)
(
	// clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// register access port
	input wire led_pwm_pkg::reg_byte_t reg_addr_in,
	input wire led_pwm_pkg::reg_byte_t reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output led_pwm_pkg::reg_byte_t reg_rdata_out,
	// open-drain ports
	input wire logic [7:0] port_in,
	output logic [7:0] port_out,
	output logic [7:0] port_oe_out,
	// ninth output pin
	output logic ninth_output_out,
	output logic ninth_output_oe_out,
	// status
	output logic pwm_running_out
);
	import led_pwm_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	reg_byte_t phase0_reg;
	reg_byte_t phase1_reg;
	reg_byte_t dir_reg;
	reg_byte_t master_reg;
	logic [`CFG_WIDTH-1:0] cfg_reg;
	nibble_t indiv_reg [0:7];
	reg_byte_t rdata_reg;
	reg_byte_t rdata_next;
	logic [7:0] in_meta_reg;
	logic [7:0] in_sync_reg;
	logic [2:0] indiv_idx;

	assign indiv_idx = 3'((reg_addr_in - `ADDR_INDIV_BASE) << 1);

	always_ff @(posedge clock_in)
	begin
		in_meta_reg <= port_in;
		in_sync_reg <= in_meta_reg;
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			phase0_reg <= `RST_PHASE;
			phase1_reg <= `RST_PHASE;
			dir_reg <= `RST_DIR;
			master_reg <= `RST_MASTER;
			cfg_reg <= `RST_CONFIG;
			for (int i = 0; i < 8; i++)
				indiv_reg[i] <= `RST_INDIV;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`ADDR_PHASE_ZERO: phase0_reg <= reg_wdata_in;
				`ADDR_PHASE_ONE: phase1_reg <= reg_wdata_in;
				`ADDR_PORT_DIR: dir_reg <= reg_wdata_in;
				`ADDR_MASTER: master_reg <= reg_wdata_in;
				`ADDR_CONFIG: cfg_reg <= reg_wdata_in[`CFG_WIDTH-1:0];
				default:
					if (reg_addr_in >= `ADDR_INDIV_BASE &&
						reg_addr_in <= `ADDR_INDIV_LAST)
					begin
						indiv_reg[indiv_idx] <= reg_wdata_in[3:0];
						indiv_reg[indiv_idx + 3'h1] <= reg_wdata_in[7:4];
					end
			endcase
		end
	end

	always_comb
	begin
		rdata_next = 8'h00;
		case (reg_addr_in)
			`ADDR_INPUT_LEVELS: rdata_next = in_sync_reg;
			`ADDR_PHASE_ZERO: rdata_next = phase0_reg;
			`ADDR_PHASE_ONE: rdata_next = phase1_reg;
			`ADDR_PORT_DIR: rdata_next = dir_reg;
			`ADDR_MASTER: rdata_next = master_reg;
			`ADDR_CONFIG: rdata_next = {2'h0, cfg_reg};
			default:
				if (reg_addr_in >= `ADDR_INDIV_BASE &&
					reg_addr_in <= `ADDR_INDIV_LAST)
					rdata_next = {indiv_reg[indiv_idx + 3'h1],
						indiv_reg[indiv_idx]};
		endcase
	end

	// unmapped reads answer zero
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
			rdata_reg <= 8'h00;
		else if (reg_rd_in)
			rdata_reg <= rdata_next;
	end

	// ****************************************
	// oscillator and step counters
	// ****************************************
	logic pwm_live;
	logic tick_reg;
	logic [12:0] div_cnt_reg;
	nibble_t slot_reg;
	nibble_t cyc_reg;
	logic period_end;
	logic run_act_reg;
	nibble_t master_act_reg;
	nibble_t ninth_act_reg;
	logic global_act_reg;
	nibble_t indiv_act_reg [0:7];

	assign pwm_live = master_reg[7:4] != 4'h0;
	assign period_end = tick_reg && slot_reg == `SLOT_LAST &&
		cyc_reg == `CYC_LAST;

	// gated divider, stopped when static
	// runs on to the period end so the shadow can drop to static
	always_ff @(posedge clock_in)
	begin
		if (srst_in || (!pwm_live && !run_act_reg))
		begin
			div_cnt_reg <= 13'h0000;
			tick_reg <= 1'b0;
		end
		else if (div_cnt_reg == 13'(OSC_DIV - 1))
		begin
			div_cnt_reg <= 13'h0000;
			tick_reg <= 1'b1;
		end
		else
		begin
			div_cnt_reg <= div_cnt_reg + 13'h0001;
			tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (srst_in || !run_act_reg)
		begin
			slot_reg <= 4'h0;
			cyc_reg <= 4'h0;
		end
		else if (tick_reg)
		begin
			cyc_reg <= cyc_reg + 4'h1;
			if (cyc_reg == `CYC_LAST)
				slot_reg <= (slot_reg == `SLOT_LAST) ? 4'h0 :
					slot_reg + 4'h1;
		end
	end

	// ****************************************
	// intensity shadow
	// ****************************************

	// load on every clock while static, and only at the period boundary while running
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			run_act_reg <= 1'b0;
			master_act_reg <= 4'h0;
			ninth_act_reg <= `RST_INDIV;
			global_act_reg <= 1'b0;
			for (int i = 0; i < 8; i++)
				indiv_act_reg[i] <= `RST_INDIV;
		end
		else if (!run_act_reg || period_end)
		begin
			run_act_reg <= pwm_live;
			master_act_reg <= master_reg[7:4];
			ninth_act_reg <= master_reg[3:0];
			global_act_reg <= cfg_reg[`CFG_GLOBAL];
			for (int i = 0; i < 8; i++)
				indiv_act_reg[i] <= indiv_reg[i];
		end
	end

	// ****************************************
	// per-output level and pwm gate
	// ****************************************
	logic [8:0] on_w;
	logic [8:0] level_w;
	nibble_t eff_w [0:8];
	logic blink_sel;

	assign blink_sel = cfg_reg[`CFG_BLINK_EN] && cfg_reg[`CFG_BLINK_FLIP];
	assign level_w[8] = blink_sel ? cfg_reg[`CFG_NINTH_PH1] :
		cfg_reg[`CFG_NINTH_PH0];

	genvar n;
	generate
		for (n = 0; n < 9; n++)
		begin : g_out
			if (n < 8)
			begin : g_port
				assign level_w[n] = blink_sel ? phase1_reg[n] :
					phase0_reg[n];
				assign eff_w[n] = global_act_reg ? ninth_act_reg :
					indiv_act_reg[n];
			end
			else
			begin : g_ninth
				assign eff_w[n] = ninth_act_reg;
			end
			// gate then duty, full is static
			assign on_w[n] = !run_act_reg || eff_w[n] == `INTENS_FULL ||
				(slot_reg < master_act_reg && cyc_reg <= eff_w[n]);
		end
	endgenerate

	// ****************************************
	// pin drive
	// ****************************************
	logic [7:0] oe_reg;
	logic ninth_oe_reg;

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			oe_reg <= 8'h00;
			ninth_oe_reg <= 1'b0;
		end
		else
		begin
			oe_reg <= (on_w[7:0] ^ level_w[7:0]) & ~dir_reg;
			// interrupt use of the pin releases it
			ninth_oe_reg <= (on_w[8] ^ level_w[8]) &&
				!cfg_reg[`CFG_INT_EN];
		end
	end

	// open drain: the data line only ever pulls low
	assign port_out = 8'h00 & oe_reg;
	assign ninth_output_out = 1'b0 & ninth_oe_reg;
	assign port_oe_out = oe_reg;
	assign ninth_output_oe_out = ninth_oe_reg;
	assign reg_rdata_out = rdata_reg;
	assign pwm_running_out = run_act_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	sequence s_rd_phase0;
		reg_rd_in && reg_addr_in == `ADDR_PHASE_ZERO;
	endsequence
	sequence s_wr_phase1;
		reg_wr_in && reg_addr_in == `ADDR_PHASE_ONE;
	endsequence

	property p_read_stored;
		s_rd_phase0 |=> reg_rdata_out == $past(phase0_reg);
	endproperty
	a_read_stored: assert property (p_read_stored)
		else $error("phase 0 read did not return stored value");

	property p_write_phase1;
		s_wr_phase1 ##1 reg_rd_in && reg_addr_in == `ADDR_PHASE_ONE
			|=> reg_rdata_out == $past(reg_wdata_in, 2);
	endproperty
	a_write_phase1: assert property (p_write_phase1)
		else $error("phase 1 write not read back");

	property p_osc_stop;
		!pwm_live && !run_act_reg |=> !tick_reg;
	endproperty
	a_osc_stop: assert property (p_osc_stop)
		else $error("oscillator ticked while pwm disabled");

	property p_tick_spacing;
		tick_reg |=> !tick_reg [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("oscillator ticks too close");

	property p_slot_range;
		slot_reg <= `SLOT_LAST;
	endproperty
	a_slot_range: assert property (p_slot_range)
		else $error("timeslot count out of range");

	property p_gate_off;
		run_act_reg && !dir_reg[0] && slot_reg >= master_act_reg &&
			eff_w[0] != `INTENS_FULL |=> port_oe_out[0] == $past(level_w[0]);
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("port driven outside gated slots");

	property p_full_static;
		run_act_reg && !dir_reg[2] && eff_w[2] == `INTENS_FULL
			|=> port_oe_out[2] == !$past(level_w[2]);
	endproperty
	a_full_static: assert property (p_full_static)
		else $error("full intensity output not static");

	property p_static_phase1;
		!run_act_reg && !dir_reg[1] && blink_sel
			|=> port_oe_out[1] == !$past(phase1_reg[1]);
	endproperty
	a_static_phase1: assert property (p_static_phase1)
		else $error("phase 1 level not applied");

	property p_shadow_hold;
		run_act_reg && !period_end |=> $stable(master_act_reg);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold)
		else $error("intensity changed inside a period");
endmodule

// File: testbench/pin_pullup_model.sv
// pull-up load on the open-drain port pins
`timescale 1ns/1ps
module pin_pullup_model
(
	// enables from the block
	input wire logic [7:0] oe_in,
	// levels seen on the pins
	output logic [7:0] pin_out
);
	// a released pin floats up to the pull-up level
	assign pin_out = ~oe_in;
endmodule

// File: testbench/led_pwm_blink_output_control_test.sv
// register and pwm tests for the led pwm block
`timescale 1ns/1ps
`include "led_pwm_cfg.svh"
module led_pwm_blink_output_control_test;
	import led_pwm_pkg::*;
	// short tick keeps each period near two thousand clocks
	localparam int DIV = 9;
	localparam int PER = 240 * DIV;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	reg_byte_t addr = 8'h00;
	reg_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	reg_byte_t rdata;
	logic [7:0] pin;
	logic [7:0] oe;
	logic [7:0] pout;
	logic ninth_oe;
	logic ninth;
	logic running;
	int n_mismatch = 0;
	int n_compared = 0;
	reg_byte_t v;
	int cnt[8];
	int ex[8];
	reg_byte_t bc[5] = '{8'h31, 8'h33, 8'h32, 8'h03, 8'h09};
	logic [8:0] bx[5] = '{9'h0a5, 9'h05a, 9'h0a5, 9'h15a, 9'h0a5};

	led_pwm_blink_output_control #(.OSC_DIV(DIV)) dut
	(
		.clock_in(clock_in),
		.srst_in(srst_in),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.port_in(pin),
		.port_out(pout),
		.port_oe_out(oe),
		.ninth_output_out(ninth),
		.ninth_output_oe_out(ninth_oe),
		.pwm_running_out(running)
	);
	pin_pullup_model load
	(
		.oe_in(oe),
		.pin_out(pin)
	);

	always #2 clock_in = ~clock_in;

	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input reg_byte_t a, input reg_byte_t d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input reg_byte_t a, output reg_byte_t d);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		@(posedge clock_in);
		#1 d = rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// pull-low time per port over one whole period
	task automatic count_on();
		cnt = '{default: 0};
		repeat (PER)
		begin
			@(posedge clock_in);
			#1;
			for (int i = 0; i < 8; i++)
				cnt[i] += oe[i];
		end
		for (int i = 0; i < 8; i++)
			if (ex[i] >= 0)
				chk(cnt[i], ex[i] * DIV);
	endtask

	// ****************
	// tests
	// ****************
	initial
	begin
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		idle(1);
		chk(oe, 8'h00);
		rd_reg(`ADDR_PHASE_ZERO, v);
		chk(v, `RST_PHASE);
		rd_reg(`ADDR_PHASE_ONE, v);
		chk(v, `RST_PHASE);
		rd_reg(8'h20, v);
		chk(v, 8'h00);
		// port 7 left as input, so its pin differs from its bit
		wr_reg(`ADDR_PORT_DIR, 8'h80);
		wr_reg(`ADDR_PHASE_ZERO, 8'h5a);
		wr_reg(`ADDR_PHASE_ONE, 8'ha5);
		idle(4);
		chk(oe, 8'h25);
		rd_reg(`ADDR_PHASE_ZERO, v);
		chk(v, 8'h5a);
		rd_reg(`ADDR_INPUT_LEVELS, v);
		chk(v, 8'hda);
		rd_reg(`ADDR_PHASE_ONE, v);
		chk(v, 8'ha5);
		// write then read back to back
		@(posedge clock_in);
		addr <= `ADDR_PHASE_ONE;
		wdata <= 8'h3c;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		idle(1);
		chk(rdata, 8'h3c);
		wr_reg(`ADDR_PHASE_ONE, 8'ha5);
		wr_reg(`ADDR_PORT_DIR, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(`ADDR_CONFIG, bc[i]);
			idle(3);
			chk({ninth_oe, oe}, bx[i]);
		end
		wr_reg(`ADDR_CONFIG, 8'h30);
		wr_reg(`ADDR_PHASE_ZERO, 8'hfa);
		// individual mode mixes static and pwm
		wr_reg(`ADDR_INDIV_BASE, 8'h07);
		wr_reg(`ADDR_MASTER, 8'hff);
		idle(2 * PER);
		chk(running, 1'b1);
		ex = '{120, 225, 240, 0, 0, 0, 0, 0};
		count_on();
		// a high bit pulls low through the ungated slots
		wr_reg(`ADDR_MASTER, 8'h1f);
		idle(2 * PER);
		ex = '{8, 239, 240, 0, 0, 0, 0, 0};
		count_on();
		wr_reg(`ADDR_PHASE_ZERO, 8'h00);
		wr_reg(`ADDR_CONFIG, 8'h34);
		wr_reg(`ADDR_MASTER, 8'h53);
		idle(2 * PER);
		ex = '{default: 20};
		count_on();
		wr_reg(`ADDR_MASTER, 8'h0f);
		idle(2 * PER);
		chk(running, 1'b0);
		chk(oe, 8'hff);
		chk({ninth, pout}, 9'h000);
		complete_run();
	end

	initial
	begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
